/* core/hpdpc_axil_slave.v */
`timescale 1ns/100ps
`include "hpdpc_regs.vh"
// One write and one read at a time; address and data may come in either order.
module hpdpc_axil_slave #(
    parameter AW = `HPDPC_ADDR_W
) (
    input wire clk_sys,
    input wire rst_b,
    input wire [AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg wrStrobe,
    output reg [AW-3:0] wrIndex,
    output reg [7:0] wrData,
    output wire [AW-3:0] rdIndex,
    input wire [7:0] rdData,
    input wire rdHit,
    input wire wrHit
);
    reg haveAw;
    reg haveW;
    reg [AW-3:0] awIdx;
    reg [7:0] wByte;
    reg wLane0;
    reg [AW-3:0] arIdx;
    reg rdPend;

    assign rdIndex = arIdx;

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `HPDPC_RESP_OKAY;
            haveAw <= 1'b0;
            haveW <= 1'b0;
            awIdx <= {(AW-2){1'b0}};
            wByte <= 8'h00;
            wLane0 <= 1'b0;
            wrStrobe <= 1'b0;
            wrIndex <= {(AW-2){1'b0}};
            wrData <= 8'h00;
        end else begin
            wrStrobe <= 1'b0;
            s_axi_awready <= !haveAw && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !haveW && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                haveAw <= 1'b1;
                s_axi_awready <= 1'b0;
                awIdx <= s_axi_awaddr[AW-1:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                haveW <= 1'b1;
                s_axi_wready <= 1'b0;
                wByte <= s_axi_wdata[7:0];
                wLane0 <= s_axi_wstrb[0];
            end
            if (haveAw && haveW && !s_axi_bvalid) begin
                wrIndex <= awIdx;
                wrData <= wByte;
                wrStrobe <= wLane0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? `HPDPC_RESP_OKAY : `HPDPC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                haveAw <= 1'b0;
                haveW <= 1'b0;
            end
        end
    end

    // Read data is decoded from arIdx one cycle after the address is taken
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `HPDPC_RESP_OKAY;
            arIdx <= {(AW-2){1'b0}};
            rdPend <= 1'b0;
        end else begin
            s_axi_arready <= !rdPend && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                arIdx <= s_axi_araddr[AW-1:2];
                rdPend <= 1'b1;
                s_axi_arready <= 1'b0;
            end
            if (rdPend && !s_axi_rvalid) begin
                s_axi_rdata <= {24'h000000, rdData};
                s_axi_rresp <= rdHit ? `HPDPC_RESP_OKAY : `HPDPC_RESP_SLVERR;
                s_axi_rvalid <= 1'b1;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                rdPend <= 1'b0;
            end
        end
    end
endmodule

/* core/hpdpc_port_remap.v */
`timescale 1ns/100ps
// Packs the enabled physical ports into contiguous logical numbers.
module hpdpc_port_remap #(
    parameter NPORT = 3
) (
    input wire [NPORT:1] portDisabled,
    output wire [1:0] enabledCount,
    output wire [2*NPORT-1:0] logicalOfPhys
);
    wire [1:0] runCount [0:NPORT];
    assign runCount[0] = 2'h0;
    genvar p;
    generate
        for (p = 1; p <= NPORT; p = p + 1) begin : g_port
            assign runCount[p] = runCount[p-1] + {1'b0, !portDisabled[p]};
            // Logical number is 1-based; zero marks a disabled port
            assign logicalOfPhys[2*p-1:2*p-2] = portDisabled[p] ? 2'h0 : runCount[p];
        end
    endgenerate
    assign enabledCount = runCount[NPORT];
endmodule

/* core/hpdpc_regs.vh */
`ifndef HPDPC_REGS_VH
`define HPDPC_REGS_VH
// Register indices; the bus byte address is four times the index
`define HPDPC_IDX_PORT_DIS_BUS 8'he9
`define HPDPC_IDX_MAX_PWR_SELF 8'hea
`define HPDPC_IDX_MAX_PWR_BUS 8'heb
`define HPDPC_IDX_CTRL_CUR_SELF 8'hec
`define HPDPC_IDX_MODE 8'hf8
`define HPDPC_IDX_STATUS 8'hf9
`define HPDPC_ADDR_W 12
// Reset values
`define HPDPC_RST_PORT_DIS 8'h00
`define HPDPC_RST_MAX_PWR_SELF 8'h00
`define HPDPC_RST_MAX_PWR_BUS 8'h00
`define HPDPC_RST_CTRL_CUR_SELF 8'h32
// Port mask layout
`define HPDPC_PORT_LO 1
`define HPDPC_PORT_HI 3
`define HPDPC_PORT_FIELD 8'h0e
// Mode register fields
`define HPDPC_MODE_BUS_POWERED 0
`define HPDPC_MODE_USE_DEFAULT 1
// AXI responses
`define HPDPC_RESP_OKAY 2'h0
`define HPDPC_RESP_SLVERR 2'h2
`endif

/* core/hpdpc_top.v */
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "hpdpc_regs.vh"
// Behaviour
// R1: A one in a bus-powered disable mask bit disables that port, a zero leaves it available.
// R2: Mask bits 3, 2 and 1 control physical ports 3, 2 and 1; bits 7..4 and 0 are reserved.
// R3: A disabled port is held off permanently; the host can neither enable nor enumerate it.
// R4: Any combination may be disabled; only the enabled count is reported, ports are renumbered.
// R5: With the internal default selected, the disable selection comes from the two strap pins.
// R6: Self-powered max power is reported in 2 mA units and covers hub, board and peripheral.
// R7: Bus-powered max power is reported in 2 mA units with the same coverage.
// R8: Controller self-powered current is reported in 2 mA units, excluding a fixed peripheral.
// R9: Controller self-powered current resets to 50, meaning 100 mA.
// R10: The configuring party keeps both self-powered current values at or below 100 mA.
// R11: The bus-powered mask and power value apply only while the hub runs bus-powered.
module hpdpc_top #(
    parameter NPORT = 3,
    parameter AW = `HPDPC_ADDR_W
) (
    input wire clk_sys,
    input wire rst_b,
    input wire [AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [1:0] port_disable_strap_pins,
    output reg [NPORT:1] portEnable,
    output reg [1:0] reportedPortCount,
    output reg [2*NPORT-1:0] portLogicalNumber,
    output reg [7:0] reportedMaxPower,
    output reg [7:0] reportedControllerCurrent
);
    reg [7:0] port_disable_bus_powered;
    reg [7:0] max_power_self_powered;
    reg [7:0] max_power_bus_powered;
    reg [7:0] controller_current_self_powered;
    reg busPowered;
    reg useDefault;
    reg [1:0] strapLatch;
    reg strapTaken;

    wire wrStrobe;
    wire [AW-3:0] wrIndex;
    wire [7:0] wrData;
    wire [AW-3:0] rdIndex;
    reg [7:0] rdData;
    reg rdHit;
    reg wrHit;

    hpdpc_axil_slave #(.AW(AW)) u_bus (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wrStrobe(wrStrobe),
        .wrIndex(wrIndex),
        .wrData(wrData),
        .rdIndex(rdIndex),
        .rdData(rdData),
        .rdHit(rdHit),
        .wrHit(wrHit)
    );

    // Address that the pending write will use, for its response code
    reg [AW-3:0] pendWrIdx;
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            pendWrIdx <= {(AW-2){1'b0}};
        end else if (s_axi_awvalid && s_axi_awready) begin
            pendWrIdx <= s_axi_awaddr[AW-1:2];
        end
    end

    function known;
        input [AW-3:0] idx;
        begin
            known = (idx == `HPDPC_IDX_PORT_DIS_BUS) || (idx == `HPDPC_IDX_MAX_PWR_SELF) ||
                    (idx == `HPDPC_IDX_MAX_PWR_BUS) || (idx == `HPDPC_IDX_CTRL_CUR_SELF) ||
                    (idx == `HPDPC_IDX_MODE) || (idx == `HPDPC_IDX_STATUS);
        end
    endfunction

    always @* begin
        wrHit = known(pendWrIdx);
    end

    // Strap sampled on the first clock after reset release, never inside reset
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            strapLatch <= 2'h0;
            strapTaken <= 1'b0;
        end else if (!strapTaken) begin
            strapLatch <= port_disable_strap_pins; // [R5]
            strapTaken <= 1'b1;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            port_disable_bus_powered <= `HPDPC_RST_PORT_DIS;
            max_power_self_powered <= `HPDPC_RST_MAX_PWR_SELF;
            max_power_bus_powered <= `HPDPC_RST_MAX_PWR_BUS;
            controller_current_self_powered <= `HPDPC_RST_CTRL_CUR_SELF; // [R9]
            busPowered <= 1'b0;
            useDefault <= 1'b0;
        end else if (wrStrobe) begin
            case (wrIndex)
                `HPDPC_IDX_PORT_DIS_BUS: begin
                    // Reserved bits are kept at zero
                    port_disable_bus_powered <= wrData & `HPDPC_PORT_FIELD; // [R2]
                end
                `HPDPC_IDX_MAX_PWR_SELF: begin
                    max_power_self_powered <= wrData;
                end
                `HPDPC_IDX_MAX_PWR_BUS: begin
                    max_power_bus_powered <= wrData;
                end
                `HPDPC_IDX_CTRL_CUR_SELF: begin
                    // Not clamped: staying within 100 mA is the configuring party's job
                    controller_current_self_powered <= wrData; // [R10]
                end
                `HPDPC_IDX_MODE: begin
                    busPowered <= wrData[`HPDPC_MODE_BUS_POWERED];
                    useDefault <= wrData[`HPDPC_MODE_USE_DEFAULT];
                end
                default: begin
                end
            endcase
        end
    end

    // Strap bits stand in for ports 1 and 2; port 3 has no strap
    wire [NPORT:1] strapMask = {1'b0, strapLatch};
    wire [NPORT:1] regMask = port_disable_bus_powered[`HPDPC_PORT_HI:`HPDPC_PORT_LO]; // [R2]
    wire [NPORT:1] activeMask = useDefault ? strapMask : regMask; // [R5]
    // Mask has no effect while self-powered
    wire [NPORT:1] effMask = busPowered ? activeMask : {NPORT{1'b0}}; // [R11]

    wire [1:0] enabledCount;
    wire [2*NPORT-1:0] logicalOfPhys;
    hpdpc_port_remap #(.NPORT(NPORT)) u_remap (
        .portDisabled(effMask),
        .enabledCount(enabledCount),
        .logicalOfPhys(logicalOfPhys)
    );

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            portEnable <= {NPORT{1'b0}};
            reportedPortCount <= 2'h0;
            portLogicalNumber <= {(2*NPORT){1'b0}};
            reportedMaxPower <= 8'h00;
            reportedControllerCurrent <= `HPDPC_RST_CTRL_CUR_SELF;
        end else begin
            portEnable <= ~effMask; // [R1] [R3]
            reportedPortCount <= enabledCount; // [R4]
            portLogicalNumber <= logicalOfPhys; // [R4]
            // Values in 2 mA units go out unchanged
            reportedMaxPower <= busPowered ? max_power_bus_powered // [R7] [R11]
                                           : max_power_self_powered; // [R6]
            reportedControllerCurrent <= controller_current_self_powered; // [R8]
        end
    end

    always @* begin
        rdHit = known(rdIndex);
        case (rdIndex)
            `HPDPC_IDX_PORT_DIS_BUS: rdData = port_disable_bus_powered;
            `HPDPC_IDX_MAX_PWR_SELF: rdData = max_power_self_powered;
            `HPDPC_IDX_MAX_PWR_BUS: rdData = max_power_bus_powered;
            `HPDPC_IDX_CTRL_CUR_SELF: rdData = controller_current_self_powered;
            `HPDPC_IDX_MODE: rdData = {6'h00, useDefault, busPowered};
            `HPDPC_IDX_STATUS: rdData = {2'h0, enabledCount, 1'b0, effMask};
            default: rdData = 8'h00;
        endcase
    end
endmodule

/* tb/hpdpc_host_model.sv */
`timescale 1ns/100ps
module hpdpc_host_model (
    input wire logic clk_sys,
    input wire logic enumerate,
    input wire logic [1:0] reportedPortCount,
    input wire logic [7:0] reportedMaxPower,
    input wire logic [7:0] reportedControllerCurrent,
    output logic [1:0] seenPorts,
    output logic [9:0] hubPowerMa,
    output logic [9:0] ctrlCurrentMa
);
    // Descriptor figures come in 2 mA steps; scaled once per enumeration
    always @(posedge clk_sys) begin
        if (enumerate) begin
            seenPorts <= reportedPortCount;
            hubPowerMa <= {1'h0, reportedMaxPower, 1'h0};
            ctrlCurrentMa <= {1'h0, reportedControllerCurrent, 1'h0};
        end
    end
endmodule

/* tb/hpdpc_properties.sv */
`timescale 1ns/100ps
module hpdpc_checker #(
    parameter NPORT = 3
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NPORT:1] portEnable,
    input wire logic [1:0] reportedPortCount,
    input wire logic [2*NPORT-1:0] portLogicalNumber,
    input wire logic [7:0] reportedControllerCurrent
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_count_matches: assert property (reportedPortCount == $countones(portEnable))
        else $error("port count differs from enabled ports");
    a_off_unnumbered: assert property (!portEnable[1] |-> portLogicalNumber[1:0] == 2'h0)
        else $error("disabled port has a number");
    a_first_is_one: assert property (portEnable[1] |-> portLogicalNumber[1:0] == 2'h1)
        else $error("first port not numbered one");
    a_last_in_range: assert property (portLogicalNumber[5:4] <= reportedPortCount)
        else $error("port number beyond count");
    a_current_default: assert property (disable iff (1'h0) !rst_b |=> reportedControllerCurrent == 8'h32)
        else $error("controller current not at default");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read not answered");
    c_write_done: cover property (s_axi_bvalid && s_axi_bready);
    c_all_off: cover property (reportedPortCount == 2'h0);
    c_read_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind hpdpc_top hpdpc_checker #(.NPORT(NPORT)) i_checker (.clk_sys, .rst_b, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .portEnable,
    .reportedPortCount, .portLogicalNumber, .reportedControllerCurrent);

/* tb/hub_port_disable_power_config_tb.sv */
`timescale 1ns/100ps
module hub_port_disable_power_config_tb;
    logic clk_sys = 1'h0;
    logic rst_b = 1'h0;
    logic [11:0] awAddr = 12'h0, arAddr = 12'h0;
    logic awValid = 1'h0, wValid = 1'h0, bReady = 1'h0, arValid = 1'h0, rReady = 1'h0;
    logic enumerate = 1'h0;
    logic [31:0] wData = 32'h0;
    logic [3:0] wStrb = 4'h0;
    logic [1:0] strap = 2'h1;
    logic [1:0] resp;
    logic [31:0] data;
    wire awReady, wReady, bValid, arReady, rValid;
    wire [1:0] bResp, rResp, portCount, seenPorts;
    wire [31:0] rData;
    wire [3:1] portEnable;
    wire [5:0] logicalNum;
    wire [7:0] maxPower, ctrlCurrent;
    wire [9:0] hubMa, ctrlMa;
    int fails = 0;
    int compares = 0;

    initial forever #4 clk_sys = ~clk_sys;

    hpdpc_top #(.NPORT(3), .AW(12)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .port_disable_strap_pins(strap), .portEnable(portEnable), .reportedPortCount(portCount),
        .portLogicalNumber(logicalNum), .reportedMaxPower(maxPower),
        .reportedControllerCurrent(ctrlCurrent));

    hpdpc_host_model i_host (.clk_sys(clk_sys), .enumerate(enumerate),
        .reportedPortCount(portCount), .reportedMaxPower(maxPower),
        .reportedControllerCurrent(ctrlCurrent), .seenPorts(seenPorts), .hubPowerMa(hubMa),
        .ctrlCurrentMa(ctrlMa));

    task automatic summarize;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Register index times four gives the byte address
    task automatic wrReg(input logic [7:0] idx, input logic [7:0] val, input logic [3:0] strb);
        int n;
        @(posedge clk_sys);
        awAddr <= {2'h0, idx, 2'h0};
        wData <= {24'h0, val};
        wStrb <= strb;
        awValid <= 1'h1;
        wValid <= 1'h1;
        bReady <= 1'h1;
        for (n = 0; n < 100 && !(bValid && bReady); n++) begin
            @(posedge clk_sys);
            if (awValid && awReady)
                awValid <= 1'h0;
            if (wValid && wReady)
                wValid <= 1'h0;
        end
        bReady <= 1'h0;
        resp = bResp;
        if (n == 100) begin
            chk("write timeout", 1, 0);
            summarize();
        end
    endtask

    task automatic rdReg(input logic [7:0] idx);
        int n;
        @(posedge clk_sys);
        arAddr <= {2'h0, idx, 2'h0};
        arValid <= 1'h1;
        rReady <= 1'h1;
        for (n = 0; n < 100 && !(rValid && rReady); n++) begin
            @(posedge clk_sys);
            if (arValid && arReady)
                arValid <= 1'h0;
        end
        rReady <= 1'h0;
        resp = rResp;
        data = rData;
        if (n == 100) begin
            chk("read timeout", 1, 0);
            summarize();
        end
    endtask

    task automatic enumHost;
        repeat (3) @(posedge clk_sys);
        enumerate <= 1'h1;
        @(posedge clk_sys);
        enumerate <= 1'h0;
        @(posedge clk_sys);
    endtask

    initial begin
        int i;
        int p;
        int k;
        logic [5:0] exLog;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'h1;
        repeat (2) @(posedge clk_sys);
        chk("ctrlCurrent", ctrlCurrent, 8'h32);
        chk("enable self", portEnable, 3'h7);
        for (i = 0; i < 4; i++) begin
            rdReg(8'he9 + i[7:0]);
            chk("reset value", data, (i == 3) ? 32'h32 : 32'h0);
            chk("mapped rresp", resp, 2'h0);
        end
        rdReg(8'h10);
        chk("unmapped rresp", resp, 2'h2);
        chk("unmapped rdata", data, 32'h0);
        wrReg(8'h11, 8'h5a, 4'h1);
        chk("unmapped bresp", resp, 2'h2);
        wrReg(8'hf8, 8'h01, 4'h1);
        chk("mode bresp", resp, 2'h0);
        for (i = 0; i < 8; i++) begin
            wrReg(8'he9, {4'hf, i[2:0], 1'h1}, 4'h1);
            rdReg(8'he9);
            chk("mask readback", data, {28'h0, i[2:0], 1'h0});
            chk("portEnable", portEnable, {29'h0, ~i[2:0]});
            k = 0;
            exLog = 6'h0;
            for (p = 1; p <= 3; p++) begin
                if (!i[p-1]) begin
                    k++;
                    exLog[2*p-1 -: 2] = k[1:0];
                end
            end
            chk("port count", portCount, k);
            chk("logical numbers", logicalNum, exLog);
        end
        wrReg(8'hea, 8'h32, 4'h1);
        wrReg(8'heb, 8'h64, 4'h1);
        enumHost();
        chk("bus power", maxPower, 8'h64);
        chk("host bus mA", hubMa, 10'hc8);
        chk("host ports", seenPorts, 2'h0);
        wrReg(8'hf8, 8'h00, 4'h1);
        wrReg(8'hec, 8'h19, 4'h1);
        wrReg(8'hec, 8'h30, 4'h0);
        enumHost();
        chk("self power", maxPower, 8'h32);
        chk("self enable", portEnable, 3'h7);
        chk("host self mA", hubMa, 10'h64);
        chk("host ctrl mA", ctrlMa, 10'h32);
        rdReg(8'hec);
        chk("ctrl readback", data, 32'h19);
        wrReg(8'hf8, 8'h03, 4'h1);
        enumHost();
        chk("strap enable", portEnable, 3'h6);
        chk("strap count", portCount, 2'h2);
        chk("strap numbers", logicalNum, 6'h24);
        rdReg(8'hf8);
        chk("mode readback", data, 32'h3);
        rdReg(8'hf9);
        chk("status", data, 32'h21);
        // Second reset with the other strap bit set; straps are only taken after reset
        strap <= 2'h2;
        rst_b <= 1'h0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'h1;
        repeat (2) @(posedge clk_sys);
        chk("reset ctrl", ctrlCurrent, 8'h32);
        chk("reset enable", portEnable, 3'h7);
        rdReg(8'he9);
        chk("reset mask", data, 32'h0);
        wrReg(8'hf8, 8'h03, 4'h1);
        enumHost();
        chk("strap2 enable", portEnable, 3'h5);
        chk("strap2 numbers", logicalNum, 6'h21);
        chk("host strap ports", seenPorts, 2'h2);
        summarize();
    end
endmodule
